// ### hall_regs_pkg.sv
/*
  package of the hall sensor result-register block: register offsets, field
  positions, reset values, timing figures, power modes and carrier structs.
  assumes a 100 MHz reference clock and a register port at printed offsets.
*/
//
// Contract
// - registers always readable; writes need customer access mode enabled
// - power-mode field writable even without customer access mode
// - inactive-period field 6:4 sets duty-cycle inactive count, eight durations
// - readback-repeat field 3:2 selects single read, fast loop or full loop
// - power-mode field 1:0: 0 active, 1 sleep, 2 duty-cycled low power
// - upper word: X, Y, Z upper bytes at 31:24, 23:16, 15:8; temp 5:0
// - upper word bit 7 set on new sample, cleared on upper word read
// - upper word bit 6 set on event; latched until one written if enabled
// - lower word bit 20 high while non-volatile event flag write runs
// - lower word: X, Y, Z lower nibbles at 19:16, 15:12, 11:8; temp 5:0
// - lower word bits 7:6 report hall sensing scheme of current readout
// - axis value is 12-bit two's complement, upper byte then lower nibble
// - host reads both words in one 8-byte read; device keeps one sample (code also queues up to 16 in sample_fifo)
// - temperature is 12-bit code split over both result words
// - temperature valid within 8 ms of power-on, refreshed every 8 ms
// - duty-cycled mode refreshes temperature once per ten cycles
// - sleep keeps bus alive but freezes magnetic and temperature results
// - leaving sleep waits the power-on delay before normal operation
// - duty-cycled mode alternates active measuring and inactive states
// - inactive codes 0..7 mean 0.5,1,5,10,50,100,500,1000 ms
// - with latching set, event status and output stay set after condition
package hall_regs_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CTRL  = 8'h27;
  localparam logic [7:0] ADDR_UPPER = 8'h28;
  localparam logic [7:0] ADDR_LOWER = 8'h29;

  // control word fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_LOOP_LSB  = 2;
  localparam int CTRL_IDLE_LSB  = 4;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // result word fields
  localparam int UP_NEW_BIT   = 7;
  localparam int UP_EVENT_BIT = 6;
  localparam int LO_NVW_BIT   = 20;
  localparam int LO_HALL_LSB  = 6;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int TICK_US        = 1;
  localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
  localparam int TEMP_PERIOD_MS = 8;
  localparam int TEMP_PERIOD_US = TEMP_PERIOD_MS * 1000;
  localparam int POD_US         = 500;
  localparam int NV_WRITE_US    = 100;
  localparam int TEMP_DC_CYCLES = 10;
  localparam int US_W           = 20;

  // inactive durations in microseconds, index = field code
  localparam logic [US_W-1:0] IDLE_US [8] = '{
    20'd500, 20'd1000, 20'd5000, 20'd10000,
    20'd50000, 20'd100000, 20'd500000, 20'd1000000
  };

  // ==========================================================================
  // power modes and sequencer states
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'h0,
    PM_SLEEP  = 2'h1,
    PM_DUTY   = 2'h2,
    PM_RSVD   = 2'h3
  } power_mode_t;

  typedef enum logic [2:0] {
    ST_POD,
    ST_ACTIVE,
    ST_SLEEP,
    ST_DC_MEAS,
    ST_DC_IDLE
  } seq_state_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
    logic [11:0] temp;
    logic [1:0]  hall;
  } sample_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// ### hall_result_regs.sv
/*
  hall sensor result registers and power-mode sequencer, plus the sample fifo
  that sits between the measurement front end and the result words.
  assumes a synchronous register port at printed offsets driven by the bus
  front end, and samples and event levels from the measurement core.
*/
`timescale 1ns/100ps

// ============================================================================
// sample fifo
module sample_fifo #(
  parameter int WIDTH = 50,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  import hall_regs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
  } fifo_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_t      st;
  fifo_state_t      next_st;
  logic             push;
  logic             pop;

  // honest full and empty from the fill count
  assign o_in_ready  = (st.count != (AW+1)'(DEPTH));
  assign o_out_valid = (st.count != '0);
  assign o_out_data  = mem[st.rptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wptr = (st.wptr == AW'(DEPTH-1)) ? '0 : st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = (st.rptr == AW'(DEPTH-1)) ? '0 : st.rptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[st.wptr] <= i_in_data;
    end
  end

endmodule // sample_fifo

// ============================================================================
// result registers and power sequencer
module hall_result_regs #(
  parameter int TICK_DIV    = hall_regs_pkg::TICK_CYCLES,
  parameter int POD_TIME    = hall_regs_pkg::POD_US,
  parameter int TEMP_PERIOD = hall_regs_pkg::TEMP_PERIOD_US,
  parameter int NV_TIME     = hall_regs_pkg::NV_WRITE_US,
  parameter int FIFO_DEPTH  = 16
) (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_b,
  input  wire hall_regs_pkg::reg_req_t  i_req,
  input  wire logic                     i_burst_hold,
  input  wire logic                     i_access_en,
  output logic [31:0]                   o_rdata,
  input  wire logic                     i_smp_valid,
  input  wire hall_regs_pkg::sample_t   i_smp,
  output logic                          o_smp_ready,
  input  wire logic                     i_event_trip,
  input  wire logic                     i_event_latch_en,
  input  wire logic                     i_nv_record_en,
  output logic                          o_event_b,
  output logic                          o_measuring,
  output logic                          o_temp_sample,
  output logic [1:0]                    o_loop_mode,
  output logic                          o_ready
);
  import hall_regs_pkg::*;

  typedef struct packed {
    logic [6:0]      ctrl;
    seq_state_t      seq;
    logic [US_W-1:0] us_cnt;
    logic [15:0]     div_cnt;
    logic [US_W-1:0] temp_cnt;
    logic [3:0]      dc_cycles;
    logic            temp_due;
    logic [US_W-1:0] nv_cnt;
    logic            nv_busy;
    logic            event_flag;
    logic            event_prev;
    logic            new_data;
    sample_t         res;
    logic [31:0]     rdata;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  sample_t     fifo_data;
  logic        fifo_valid;
  logic        take;
  logic        tick;
  logic        upd_ok;
  power_mode_t mode;

  sample_fifo #(
    .WIDTH ($bits(sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (i_smp_valid),
    .i_in_data   (i_smp),
    .o_in_ready  (o_smp_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (take)
  );

  // one-cycle microsecond enable from the clock divider
  assign tick = (st.div_cnt == 16'(TICK_DIV - 1));
  assign mode = power_mode_t'(st.ctrl[CTRL_MODE_LSB +: 2]);

  // results move only while measuring and not inside a burst read
  assign upd_ok = (st.seq == ST_ACTIVE) || (st.seq == ST_DC_MEAS);
  assign take   = upd_ok && !i_burst_hold;

  always_comb begin
    next_st        = st;
    o_temp_sample  = 1'b0;

    // divider
    next_st.div_cnt = tick ? '0 : st.div_cnt + 16'h0001;

    // register writes: mode field always unless code 3, the rest needs access mode
    if (i_req.wr && i_req.addr == ADDR_CTRL) begin
      if (i_req.wdata[1:0] != 2'h3) begin
        next_st.ctrl[CTRL_MODE_LSB +: 2] = i_req.wdata[1:0];
      end
      if (i_access_en) begin
        next_st.ctrl[CTRL_LOOP_LSB +: 2] = i_req.wdata[3:2];
        next_st.ctrl[CTRL_IDLE_LSB +: 3] = i_req.wdata[6:4];
      end
    end

    // power sequencer
    unique case (st.seq)
      ST_POD: begin
        if (tick) begin
          next_st.us_cnt = st.us_cnt + 1'b1;
        end
        if (st.us_cnt >= US_W'(POD_TIME)) begin
          next_st.us_cnt   = '0;
          next_st.temp_cnt = '0;
          next_st.temp_due = 1'b1;
          next_st.seq      = (mode == PM_DUTY) ? ST_DC_MEAS : ST_ACTIVE;
          if (mode == PM_SLEEP) begin
            next_st.seq = ST_SLEEP;
          end
        end
      end
      ST_ACTIVE: begin
        if (tick) begin
          next_st.temp_cnt = st.temp_cnt + 1'b1;
        end
        if (st.temp_cnt >= US_W'(TEMP_PERIOD - 1) && tick) begin
          next_st.temp_cnt = '0;
          next_st.temp_due = 1'b1;
        end
        if (mode == PM_SLEEP) begin
          next_st.seq = ST_SLEEP;
        end else if (mode == PM_DUTY) begin
          next_st.seq       = ST_DC_MEAS;
          next_st.dc_cycles = '0;
        end
      end
      ST_SLEEP: begin
        if (mode != PM_SLEEP) begin
          next_st.seq    = ST_POD;
          next_st.us_cnt = '0;
        end
      end
      ST_DC_MEAS: begin
        if (take && fifo_valid) begin
          next_st.seq    = ST_DC_IDLE;
          next_st.us_cnt = '0;
        end
        if (mode == PM_SLEEP) begin
          next_st.seq = ST_SLEEP;
        end else if (mode == PM_ACTIVE) begin
          next_st.seq = ST_ACTIVE;
        end
      end
      ST_DC_IDLE: begin
        if (tick) begin
          next_st.us_cnt = st.us_cnt + 1'b1;
        end
        if (st.us_cnt >= IDLE_US[st.ctrl[CTRL_IDLE_LSB +: 3]]) begin
          next_st.seq    = ST_DC_MEAS;
          next_st.us_cnt = '0;
          if (st.dc_cycles == 4'(TEMP_DC_CYCLES - 1)) begin
            next_st.dc_cycles = '0;
            next_st.temp_due  = 1'b1;
          end else begin
            next_st.dc_cycles = st.dc_cycles + 1'b1;
          end
        end
        if (mode == PM_SLEEP) begin
          next_st.seq = ST_SLEEP;
        end else if (mode == PM_ACTIVE) begin
          next_st.seq = ST_ACTIVE;
        end
      end
    endcase

    // new-data flag: clear on read of the upper word, set wins
    if (i_req.rd && i_req.addr == ADDR_UPPER) begin
      next_st.new_data = 1'b0;
    end

    // sample capture: magnetic always, temperature when due
    if (take && fifo_valid) begin
      next_st.res.x    = fifo_data.x;
      next_st.res.y    = fifo_data.y;
      next_st.res.z    = fifo_data.z;
      next_st.res.hall = fifo_data.hall;
      next_st.new_data = 1'b1;
      if (st.temp_due) begin
        next_st.res.temp = fifo_data.temp;
        next_st.temp_due = 1'b0;
        o_temp_sample    = 1'b1;
      end
    end

    // event flag: latched until written one, else follows the level
    next_st.event_prev = i_event_trip;
    if (i_event_latch_en) begin
      if (i_req.wr && i_req.addr == ADDR_UPPER && i_access_en
          && i_req.wdata[UP_EVENT_BIT]) begin
        next_st.event_flag = 1'b0;
      end
      if (i_event_trip) begin
        next_st.event_flag = 1'b1;
      end
    end else begin
      next_st.event_flag = i_event_trip;
    end

    // non-volatile event record busy window
    if (st.nv_busy) begin
      if (tick) begin
        next_st.nv_cnt = st.nv_cnt + 1'b1;
      end
      if (st.nv_cnt >= US_W'(NV_TIME)) begin
        next_st.nv_busy = 1'b0;
      end
    end else if (i_event_trip && !st.event_prev && i_nv_record_en) begin
      next_st.nv_busy = 1'b1;
      next_st.nv_cnt  = '0;
    end

    // read data, one cycle after the request
    if (i_req.rd) begin
      unique case (i_req.addr)
        ADDR_CTRL: begin
          next_st.rdata = {25'h0000000, st.ctrl};
        end
        ADDR_UPPER: begin
          next_st.rdata = {st.res.x[11:4], st.res.y[11:4], st.res.z[11:4],
                           st.new_data, st.event_flag,
                           st.res.temp[11:6]};
        end
        ADDR_LOWER: begin
          next_st.rdata = {11'h000, st.nv_busy, st.res.x[3:0],
                           st.res.y[3:0], st.res.z[3:0], st.res.hall,
                           st.res.temp[5:0]};
        end
        default: begin
          next_st.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st      <= '0;
      st.ctrl <= CTRL_RESET;
      st.seq  <= ST_POD;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign o_rdata     = st.rdata;
  assign o_event_b   = !st.event_flag;
  assign o_measuring = upd_ok;
  assign o_loop_mode = st.ctrl[CTRL_LOOP_LSB +: 2];
  assign o_ready     = (st.seq != ST_POD);

endmodule // hall_result_regs

// ### hall_regs_chk_sva.sv
/*
  checker of the result-register block: read answers, control word locking,
  event flag, sleep stop and power-on delay, seen from the top ports only.
  assumes a single clock with an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module hall_regs_chk #(
  parameter int TICK_DIV = 2,
  parameter int POD_TIME = 5
) (
  input wire logic                    i_ref_clk,
  input wire logic                    i_rst_b,
  input wire hall_regs_pkg::reg_req_t i_req,
  input wire logic                    i_access_en,
  input wire logic [31:0]             o_rdata,
  input wire logic                    i_event_trip,
  input wire logic                    i_event_latch_en,
  input wire logic                    o_event_b,
  input wire logic                    o_measuring,
  input wire logic                    o_temp_sample,
  input wire logic [1:0]              o_loop_mode,
  input wire logic                    o_ready
);
  import hall_regs_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================================
  // helpers
  logic [23:0] low_cnt;
  // cycles spent waiting for ready, wide enough for the full delay
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) low_cnt <= 24'h000000;
    else if (o_ready) low_cnt <= 24'h000000;
    else if (low_cnt != 24'hffffff) low_cnt <= low_cnt + 24'h000001;
  end
  sequence rd_at(a);
    i_req.rd && i_req.addr == a;
  endsequence
  sequence ctrl_wr;
    i_req.wr && i_req.addr == ADDR_CTRL;
  endsequence
  // ==========================================================================
  // properties
  a_lower_rsvd_zero: assert property (rd_at(ADDR_LOWER) |=> o_rdata[31:21] == '0)
    else $error("lower word reserved bits not zero");
  a_ctrl_rsvd_zero: assert property (rd_at(ADDR_CTRL) |=> o_rdata[31:7] == '0)
    else $error("control word reserved bits not zero");
  a_unmapped_zero: assert property (i_req.rd && !(i_req.addr inside {[8'h27:8'h29]})
    |=> o_rdata == '0)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without a read");
  a_loop_locked: assert property (ctrl_wr and !i_access_en |=> $stable(o_loop_mode))
    else $error("loop field written while locked");
  a_loop_set: assert property (ctrl_wr and i_access_en
    |=> o_loop_mode == $past(i_req.wdata[3:2]))
    else $error("loop field not taken");
  a_sleep_stops: assert property (ctrl_wr and i_req.wdata[1:0] == 2'h1
    |-> ##3 !o_measuring)
    else $error("measuring in sleep");
  a_ready_late: assert property ($rose(o_ready) |-> low_cnt >= POD_TIME * TICK_DIV)
    else $error("ready before power-on delay");
  a_event_follows: assert property (!i_event_latch_en && i_event_trip
    |=> ##[0:1] !o_event_b)
    else $error("event output not asserted");
  a_event_latched: assert property (i_event_latch_en && !o_event_b && !i_req.wr
    && !$past(i_req.wr) |=> !o_event_b)
    else $error("latched event dropped");
  a_temp_ready: assert property (o_temp_sample |-> o_ready && o_measuring)
    else $error("temperature captured outside measuring");
endmodule // hall_regs_chk

bind hall_result_regs hall_regs_chk #(.TICK_DIV(TICK_DIV), .POD_TIME(POD_TIME)) i_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(i_req), .i_access_en(i_access_en),
  .o_rdata(o_rdata), .i_event_trip(i_event_trip), .i_event_latch_en(i_event_latch_en),
  .o_event_b(o_event_b), .o_measuring(o_measuring), .o_temp_sample(o_temp_sample),
  .o_loop_mode(o_loop_mode), .o_ready(o_ready)
);

// ### reg_host.sv
/*
  register host model: one request per word access on the register port.
  assumes read data valid one cycle after the read strobe edge.
*/
`timescale 1ns/100ps
module reg_host (
  input  wire logic               i_ref_clk,
  input  wire logic [31:0]        i_rdata,
  output hall_regs_pkg::reg_req_t o_req
);
  import hall_regs_pkg::*;
  initial o_req = '0;
  // ==========================================================================
  // word write, strobe held one cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_ref_clk);
    o_req.wr <= 1'b0;
  endtask
  // word read, data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge i_ref_clk);
    o_req.rd <= 1'b0;
    @(posedge i_ref_clk);
    d = i_rdata;
  endtask
endmodule // reg_host

// ### testbench.sv
/*
  self-checking bench of the result-register block with a register host model.
  assumes shortened timing parameters: tick 2 cycles, delay 5, nv write 3.
*/
`timescale 1ns/100ps
module testbench;
  import hall_regs_pkg::*;
  logic       i_ref_clk, i_rst_b, burst, access, smp_valid, trip, latch, nvrec;
  logic       smp_ready, event_b, measuring, temp_sample, ready;
  logic [1:0] loop_mode;
  logic [31:0] rdata, v, up1, lo1, up2;
  reg_req_t   req;
  sample_t    smp;
  int         failures, check_count, temp_hits;
  // ==========================================================================
  // design and host
  hall_result_regs #(.TICK_DIV(2), .POD_TIME(5), .TEMP_PERIOD(20), .NV_TIME(3)) i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(req), .i_burst_hold(burst),
    .i_access_en(access), .o_rdata(rdata), .i_smp_valid(smp_valid), .i_smp(smp),
    .o_smp_ready(smp_ready), .i_event_trip(trip), .i_event_latch_en(latch),
    .i_nv_record_en(nvrec), .o_event_b(event_b), .o_measuring(measuring),
    .o_temp_sample(temp_sample), .o_loop_mode(loop_mode), .o_ready(ready));
  reg_host i_host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_req(req));
  // ==========================================================================
  // helpers
  // temperature capture pulses seen
  always @(posedge i_ref_clk) begin
    if (temp_sample === 1'b1) temp_hits++;
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic send(input sample_t s);
    @(posedge i_ref_clk);
    smp <= s;
    smp_valid <= 1'b1;
    @(posedge i_ref_clk);
    smp_valid <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge i_ref_clk);
    check("ready", {31'h0, ready}, 32'h1);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_ctrl;
    i_host.wr(ADDR_CTRL, 32'h0000_007e);
    i_host.rd(ADDR_CTRL, v);
    check("ctrl locked", v, 32'h0000_0002);
    access <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      i_host.wr(ADDR_CTRL, 32'hffff_ff80 | (i << 4) | ((i % 3) << 2));
      i_host.rd(ADDR_CTRL, v);
      check("ctrl", v, (i << 4) | ((i % 3) << 2));
      check("loop", {30'h0, loop_mode}, i % 3);
    end
    i_host.wr(ADDR_CTRL, 32'h0000_001f);
    i_host.rd(ADDR_CTRL, v);
    check("mode 3", v, 32'h0000_001c);
    i_host.wr(ADDR_CTRL, 32'h0000_0000);
    i_host.rd(8'h30, v);
    check("unmapped", v, 32'h0);
  endtask
  task automatic t_sample;
    send('{x: 12'hc06, y: 12'h123, z: 12'h7ff, temp: 12'hab5, hall: 2'h2});
    burst <= 1'b1;
    send('{x: 12'h801, y: 12'h3fe, z: 12'h000, temp: 12'h000, hall: 2'h0});
    i_host.rd(ADDR_UPPER, v);
    check("upper", v, 32'hc0_12_7f_aa);
    i_host.rd(ADDR_LOWER, v);
    check("lower", v, 32'h0006_3fb5);
    burst <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_host.rd(ADDR_UPPER, v);
    check("upper 2", {v[31:7], 7'h0}, 32'h80_3f_00_80);
    i_host.rd(ADDR_UPPER, v);
    check("new clear", {31'h0, v[7]}, 32'h0);
  endtask
  task automatic t_event;
    trip <= 1'b1;
    i_host.rd(ADDR_UPPER, v);
    i_host.rd(ADDR_UPPER, v);
    check("event", {v[6], event_b}, 2'b10);
    trip <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    check("event gone", {31'h0, event_b}, 32'h1);
    latch <= 1'b1;
    trip <= 1'b1;
    @(posedge i_ref_clk);
    trip <= 1'b0;
    i_host.rd(ADDR_UPPER, v);
    i_host.rd(ADDR_UPPER, v);
    check("latched", {v[6], event_b}, 2'b10);
    i_host.wr(ADDR_UPPER, 32'h0000_0040);
    i_host.rd(ADDR_UPPER, v);
    check("w1c", {v[6], event_b}, 2'b01);
    latch <= 1'b0;
    nvrec <= 1'b1;
    trip <= 1'b1;
    i_host.rd(ADDR_LOWER, v);
    check("nv busy", {31'h0, v[20]}, 32'h1);
    trip <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_host.rd(ADDR_LOWER, v);
    check("nv done", {31'h0, v[20]}, 32'h0);
  endtask
  task automatic t_duty;
    i_host.wr(ADDR_CTRL, 32'h0000_0002);
    send('{x: 12'h555, y: 12'h666, z: 12'h777, temp: 12'h888, hall: 2'h0});
    check("duty idle", {31'h0, measuring}, 32'h0);
    repeat (960) @(posedge i_ref_clk);
    check("idle span", {31'h0, measuring}, 32'h0);
    repeat (60) @(posedge i_ref_clk);
    check("duty meas", {31'h0, measuring}, 32'h1);
    i_host.wr(ADDR_CTRL, 32'h0000_0000);
  endtask
  task automatic t_sleep;
    int base;
    i_host.wr(ADDR_CTRL, 32'h0000_0001);
    repeat (4) @(posedge i_ref_clk);
    check("sleep meas", {31'h0, measuring}, 32'h0);
    repeat (16) send('{x: 12'h111, y: 12'h222, z: 12'h333, temp: 12'h444, hall: 2'h0});
    check("fifo full", {31'h0, smp_ready}, 32'h0);
    i_host.rd(ADDR_UPPER, v);
    check("frozen", {v[31:8], v[7]}, {24'h556677, 1'b1});
    access <= 1'b0;
    base = temp_hits;
    i_host.wr(ADDR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge i_ref_clk);
    check("wake", {31'h0, ready}, 32'h0);
    wait_ready();
    repeat (4) @(posedge i_ref_clk);
    check("temp pulses", temp_hits - base, 32'd1);
  endtask
  // ==========================================================================
  // clock, reset, sequence, watchdog
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    {i_rst_b, burst, access, smp_valid, trip, latch, nvrec} = '0;
    smp = '0;
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    wait_ready();
    t_ctrl();
    t_sample();
    t_event();
    t_duty();
    t_sleep();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    failures++;
    tally_and_finish();
  end
endmodule // testbench
